// >>> design/brl_pkg.sv
// Purpose: Shared constants and types for the bus release, hold-off and queue status block
// Assumes: Single clock domain at 250 MHz
// Notes: Bus phase codes follow a Gray path through the states of one bus cycle
`default_nettype none
package brl_pkg;

  // Bus interface phase reported by the core, Gray along TI-T1-T2-T3-T4
  typedef enum logic [2:0] {
    BRL_PH_IDLE = 3'h0,
    BRL_PH_ONE = 3'h1,
    BRL_PH_TWO = 3'h3,
    BRL_PH_THREE = 3'h2,
    BRL_PH_FOUR = 3'h6
  } brl_phase_t;

  // Arbiter states, Gray along own-grant-held-recover
  typedef enum logic [1:0] {
    BRL_ST_OWN = 2'h0,
    BRL_ST_GRANT = 2'h1,
    BRL_ST_HELD = 2'h3,
    BRL_ST_RECOVER = 2'h2
  } brl_state_t;

  // Queue status codes
  localparam logic [1:0] BRL_QS_NONE = 2'h0;
  localparam logic [1:0] BRL_QS_FIRST = 2'h1;
  localparam logic [1:0] BRL_QS_FLUSH = 2'h2;
  localparam logic [1:0] BRL_QS_NEXT = 2'h3;

  // Channel indices
  localparam int BRL_CH_HI = 0;
  localparam int BRL_CH_LO = 1;
  localparam int BRL_NUM_CH = 2;

endpackage
`default_nettype wire

// >>> design/brl_pulse_detect.sv
// Purpose: Detects a one-clock active-low pulse on a request/grant pin
// Assumes: Pin input is synchronous to clk_sys
// Notes: Samples are ignored while this end drives the pin, so our own grant pulse is not seen
`default_nettype none
module brl_pulse_detect (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Pin side
  input wire logic pin_in,
  input wire logic driving,
  // Result
  output logic pulse
);

  logic high_seen_reg;

  // Remember that the pin was high and undriven last cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      high_seen_reg <= 1'b0;
    end else begin
      high_seen_reg <= pin_in & ~driving;
    end
  end

  // A falling edge from an undriven high marks the other master's pulse
  assign pulse = high_seen_reg & ~pin_in & ~driving;

endmodule
`default_nettype wire

// >>> design/brl_bus_release.sv
// Purpose: Decides when the local bus is handed to another master; drives hold-off and queue status
// Assumes: Core phase and cycle flags are synchronous; request/grant pins are open-drain, active low
// Notes: One arbiter for both request/grant pins; the high priority pin wins a tie
//
// What this block does
// - Busy memory cycle: release at its end only if request came by state two.
// - Never release after a cycle moving the low byte of an odd-address word.
// - Defer release when the cycle is the first interrupt acknowledge cycle.
// - No release while a locked instruction is still executing.
// - Bus idle when request arrives: release during the following cycle.
// - Hold-off goes low at the locking prefix, stays until next instruction completes.
// - While the bus is granted, hold-off floats, weakly held high.
// - Maximum mode: hold-off low from state two of first acknowledge to second's.
// - Queue status shows the operation in the cycle right after it.
// - Queue status outputs are always driven, never floated.
// - Queue codes: 00 none, 01 first byte, 10 flush, 11 next byte.
// - Handover uses request, grant, release pulses; one idle clock follows each exchange.
`default_nettype none
module brl_bus_release (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Core bus cycle status
  input wire logic [2:0] bus_phase,
  input wire logic odd_low_byte,
  input wire logic irq_acknowledge_cycle_first,
  input wire logic irq_acknowledge_cycle_second,
  input wire logic max_mode,
  // Core instruction status
  input wire logic lock_prefix_exec,
  input wire logic instr_done,
  // Core queue events
  input wire logic queue_take_first,
  input wire logic queue_flush,
  input wire logic queue_take_next,
  // Request/grant pins, open drain
  input wire logic bus_request_grant_hi_prio_in,
  output logic bus_request_grant_hi_prio_out,
  output logic bus_request_grant_hi_prio_oe,
  input wire logic bus_request_grant_lo_prio_in,
  output logic bus_request_grant_lo_prio_out,
  output logic bus_request_grant_lo_prio_oe,
  // Hold-off pin, active low, weak pull-up outside
  output logic bus_hold_off_n_out,
  output logic bus_hold_off_n_oe,
  // Queue status pins
  output logic queue_status_hi,
  output logic queue_status_lo,
  // To core: bus floated for another master
  output logic bus_released
);

  brl_pkg::brl_state_t state_reg;
  brl_pkg::brl_state_t state_next;
  brl_pkg::brl_phase_t phase;
  logic [1:0] pin_in;
  logic [1:0] pin_drive;
  logic [1:0] req_pulse;
  logic [1:0] pending_reg;
  logic [1:0] early_reg;
  logic owner_reg;
  logic grant_go;
  logic grant_ch;
  logic lock_active_reg;
  logic irq_acknowledge_cycle_lock_reg;
  logic [1:0] qs_reg;
  logic at_idle;
  logic at_end;
  logic conds_ok;
  logic [1:0] eligible;

  assign phase = brl_pkg::brl_phase_t'(bus_phase);
  assign pin_in = {bus_request_grant_lo_prio_in, bus_request_grant_hi_prio_in};

  // One detector per request/grant pin
  genvar gi;
  generate
    for (gi = 0; gi < brl_pkg::BRL_NUM_CH; gi++) begin : g_det
      brl_pulse_detect u_det (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in(pin_in[gi]),
        .driving(pin_drive[gi]),
        .pulse(req_pulse[gi])
      );
    end
  endgenerate

  // Release decision points: end of a bus cycle, or any idle clock
  assign at_idle = (phase == brl_pkg::BRL_PH_IDLE);
  assign at_end = (phase == brl_pkg::BRL_PH_FOUR);
  // All release conditions must hold together
  assign conds_ok = ~lock_active_reg
                  & ~(at_end & odd_low_byte)
                  & ~(at_end & irq_acknowledge_cycle_first);
  // Idle bus grants on the next clock; busy cycle needs an early request
  assign eligible = pending_reg & (at_idle ? 2'h3 : (at_end ? early_reg : 2'h0));
  assign grant_go = (state_reg == brl_pkg::BRL_ST_OWN) & conds_ok & (|eligible);
  assign grant_ch = ~eligible[brl_pkg::BRL_CH_HI]; // High priority pin wins a tie

  // Pending requests; a request after state two waits for the next cycle end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pending_reg <= 2'h0;
      early_reg <= 2'h0;
    end else begin
      for (int i = 0; i < brl_pkg::BRL_NUM_CH; i++) begin
        if (grant_go && (int'(grant_ch) == i)) begin
          pending_reg[i] <= 1'b0;
        end else if (req_pulse[i] && state_reg == brl_pkg::BRL_ST_OWN) begin
          pending_reg[i] <= 1'b1;
          // A request seen at state four is early for the next cycle end
          early_reg[i] <= (phase != brl_pkg::BRL_PH_THREE);
        end else if (at_end) begin
          early_reg[i] <= pending_reg[i]; // Failed attempt retries at the next cycle end
        end
      end
    end
  end

  // Handover sequence: grant pulse, hold, wait for release pulse, one idle clock
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      brl_pkg::BRL_ST_OWN: begin
        if (grant_go) begin
          state_next = brl_pkg::BRL_ST_GRANT;
        end
      end
      brl_pkg::BRL_ST_GRANT: begin
        state_next = brl_pkg::BRL_ST_HELD;
      end
      brl_pkg::BRL_ST_HELD: begin
        if (req_pulse[owner_reg]) begin
          state_next = brl_pkg::BRL_ST_RECOVER;
        end
      end
      brl_pkg::BRL_ST_RECOVER: begin
        state_next = brl_pkg::BRL_ST_OWN;
      end
    endcase
  end

  // State and owner registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= brl_pkg::BRL_ST_OWN;
      owner_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (grant_go) begin
        owner_reg <= grant_ch;
      end
    end
  end

  // Grant pulse is one clock low on the winning pin only
  always_comb begin
    pin_drive = 2'h0;
    if (state_reg == brl_pkg::BRL_ST_GRANT) begin
      pin_drive[owner_reg] = 1'b1;
    end
  end

  assign bus_request_grant_hi_prio_oe = pin_drive[brl_pkg::BRL_CH_HI];
  assign bus_request_grant_lo_prio_oe = pin_drive[brl_pkg::BRL_CH_LO];
  assign bus_request_grant_hi_prio_out = 1'b0; // Open drain: only ever pulls low
  assign bus_request_grant_lo_prio_out = 1'b0;
  assign bus_released = (state_reg != brl_pkg::BRL_ST_OWN);

  // Locked instruction: set at prefix, cleared when the next instruction completes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lock_active_reg <= 1'b0;
    end else if (lock_prefix_exec) begin
      lock_active_reg <= 1'b1;
    end else if (instr_done) begin
      lock_active_reg <= 1'b0;
    end
  end

  // Maximum mode acknowledge lock, from state two of first to state two of second
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_acknowledge_cycle_lock_reg <= 1'b0;
    end else if (max_mode && phase == brl_pkg::BRL_PH_TWO) begin
      if (irq_acknowledge_cycle_first) begin
        irq_acknowledge_cycle_lock_reg <= 1'b1;
      end else if (irq_acknowledge_cycle_second) begin
        irq_acknowledge_cycle_lock_reg <= 1'b0;
      end
    end
  end

  // Hold-off floats while another master owns the bus; pull-up keeps it high
  assign bus_hold_off_n_out = ~(lock_active_reg | irq_acknowledge_cycle_lock_reg);
  assign bus_hold_off_n_oe = (state_reg == brl_pkg::BRL_ST_OWN) || (state_reg == brl_pkg::BRL_ST_RECOVER);

  // Queue status registered one clock after the event; flush beats a take
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      qs_reg <= brl_pkg::BRL_QS_NONE;
    end else if (queue_flush) begin
      qs_reg <= brl_pkg::BRL_QS_FLUSH;
    end else if (queue_take_first) begin
      qs_reg <= brl_pkg::BRL_QS_FIRST;
    end else if (queue_take_next) begin
      qs_reg <= brl_pkg::BRL_QS_NEXT;
    end else begin
      qs_reg <= brl_pkg::BRL_QS_NONE;
    end
  end

  // Always driven, no enable exists for these pins
  assign queue_status_hi = qs_reg[1];
  assign queue_status_lo = qs_reg[0];

  // Checks
  property p_late_req;
    @(posedge clk_sys) disable iff (sys_rst)
    (state_reg == brl_pkg::BRL_ST_OWN && req_pulse == 2'h1 && pending_reg == 2'h0
     && phase == brl_pkg::BRL_PH_THREE) ##1 at_end |-> !grant_go;
  endproperty
  a_late_req: assert property (p_late_req) else $error("late request released the bus");

  property p_odd_byte;
    @(posedge clk_sys) disable iff (sys_rst)
    (at_end && odd_low_byte) |=> (state_reg != brl_pkg::BRL_ST_GRANT);
  endproperty
  a_odd_byte: assert property (p_odd_byte) else $error("release after odd low byte cycle");

  property p_irq_acknowledge_cycle_defer;
    @(posedge clk_sys) disable iff (sys_rst)
    (at_end && irq_acknowledge_cycle_first) |=> (state_reg != brl_pkg::BRL_ST_GRANT);
  endproperty
  a_irq_acknowledge_cycle_defer: assert property (p_irq_acknowledge_cycle_defer) else $error("release in first acknowledge");

  property p_locked;
    @(posedge clk_sys) disable iff (sys_rst)
    (state_reg == brl_pkg::BRL_ST_GRANT) |-> !$past(lock_active_reg);
  endproperty
  a_locked: assert property (p_locked) else $error("release during locked instruction");

  property p_idle_release;
    @(posedge clk_sys) disable iff (sys_rst)
    (state_reg == brl_pkg::BRL_ST_OWN && at_idle && pending_reg[0] && !lock_active_reg)
    |=> (state_reg == brl_pkg::BRL_ST_GRANT) && bus_request_grant_hi_prio_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("idle bus not released");

  property p_lock_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    lock_prefix_exec ##1 (!instr_done && !lock_prefix_exec)[*2] |-> !bus_hold_off_n_out;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("hold-off released early");

  property p_float;
    @(posedge clk_sys) disable iff (sys_rst)
    (state_reg == brl_pkg::BRL_ST_HELD) |-> !bus_hold_off_n_oe;
  endproperty
  a_float: assert property (p_float) else $error("hold-off driven while granted");

  property p_irq_acknowledge_cycle_lock;
    @(posedge clk_sys) disable iff (sys_rst)
    (max_mode && irq_acknowledge_cycle_first && phase == brl_pkg::BRL_PH_TWO) |=> !bus_hold_off_n_out;
  endproperty
  a_irq_acknowledge_cycle_lock: assert property (p_irq_acknowledge_cycle_lock) else $error("no hold-off in acknowledge");

  property p_queue;
    @(posedge clk_sys) disable iff (sys_rst)
    (queue_flush) |=> ({queue_status_hi, queue_status_lo} == brl_pkg::BRL_QS_FLUSH);
  endproperty
  a_queue: assert property (p_queue) else $error("queue status not shown next cycle");

  property p_queue_code;
    @(posedge clk_sys) disable iff (sys_rst)
    (!queue_flush && !queue_take_first && queue_take_next) |=> (queue_status_hi && queue_status_lo);
  endproperty
  a_queue_code: assert property (p_queue_code) else $error("wrong next-byte code");

  property p_exchange;
    @(posedge clk_sys) disable iff (sys_rst)
    (state_reg == brl_pkg::BRL_ST_HELD && req_pulse[owner_reg])
    |=> (state_reg == brl_pkg::BRL_ST_RECOVER && !grant_go) ##1 (state_reg == brl_pkg::BRL_ST_OWN);
  endproperty
  a_exchange: assert property (p_exchange) else $error("no idle clock after exchange");

  property p_retry;
    @(posedge clk_sys) disable iff (sys_rst)
    (state_reg == brl_pkg::BRL_ST_OWN && at_end && pending_reg[0] && odd_low_byte)
    |=> pending_reg[0] && early_reg[0];
  endproperty
  a_retry: assert property (p_retry) else $error("failed release dropped request");

  c_grant_hi: cover property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == brl_pkg::BRL_ST_GRANT && owner_reg == 1'b0);
  c_grant_lo: cover property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == brl_pkg::BRL_ST_GRANT && owner_reg == 1'b1);
  c_recover: cover property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == brl_pkg::BRL_ST_RECOVER);
  c_irq_acknowledge_cycle: cover property (@(posedge clk_sys) disable iff (sys_rst) irq_acknowledge_cycle_lock_reg);

endmodule
`default_nettype wire

// >>> tb/brl_far_master.sv
// Purpose: Model of another local bus master on one request/grant pin
// Assumes: Pin is open drain with a pull-up; bench gives the one-clock request pulse
// Notes: Holds the bus a fixed number of clocks, then sends the release pulse
`default_nettype none
module brl_far_master (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bench request and pin levels
  input wire logic req,
  input wire logic pin_level,
  input wire logic hold_off_level,
  // Pin drive and ownership
  output logic pull,
  output logic owns
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 2;
  logic waiting_reg;
  logic rel_reg;
  int cnt_reg;

  // Request and release are each one clock wide, active low on the pin
  assign pull = req | rel_reg;

  // Grant is the pin low while we do not pull; the bus is taken only while hold-off is high
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      waiting_reg <= 1'b0;
      owns <= 1'b0;
      rel_reg <= 1'b0;
      cnt_reg <= 0;
    end else begin
      rel_reg <= 1'b0;
      if (req) begin
        waiting_reg <= 1'b1;
      end
      if (waiting_reg && !pin_level && !pull && hold_off_level) begin
        waiting_reg <= 1'b0;
        owns <= 1'b1;
        cnt_reg <= HOLD;
      end
      if (owns) begin
        if (cnt_reg == 0) begin
          owns <= 1'b0;
          rel_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/bus_release_lock_queue_status_tb.sv
// Purpose: Self-checking bench for bus release, hold-off and queue status
// Assumes: Inputs change 1 ns after the rising edge; far masters are behavioural
// Notes: Each scenario runs two bus cycles (none in the idle-bus ones) and then idles until the bus comes back
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module bus_release_lock_queue_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, sys_rst, odd, ack1, ack2, max_mode, lock, done, q_first, q_flush, q_next;
  logic [2:0] bus_phase;
  logic hi_oe, lo_oe, hi_pull, lo_pull, hi_pin, lo_pin, hold_out, hold_oe, hold_lvl;
  logic qs_hi, qs_lo, released, req_hi, req_lo, hi_out, lo_out;
  int errors = 0;
  int check_count = 0;
  logic [2:0] seq [4] = '{brl_pkg::BRL_PH_ONE, brl_pkg::BRL_PH_TWO, brl_pkg::BRL_PH_THREE,
    brl_pkg::BRL_PH_FOUR};

  // Open-drain wires resolve to the pull-up level when nobody pulls
  assign hi_pin = !hi_pull && (hi_oe ? hi_out : 1'b1);
  assign lo_pin = !lo_pull && (lo_oe ? lo_out : 1'b1);
  assign hold_lvl = hold_oe ? hold_out : 1'b1;

  brl_bus_release brl_bus_release_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_phase(bus_phase),
    .odd_low_byte(odd), .irq_acknowledge_cycle_first(ack1), .irq_acknowledge_cycle_second(ack2),
    .max_mode(max_mode), .lock_prefix_exec(lock), .instr_done(done), .queue_take_first(q_first),
    .queue_flush(q_flush), .queue_take_next(q_next), .bus_request_grant_hi_prio_in(hi_pin),
    .bus_request_grant_hi_prio_out(hi_out), .bus_request_grant_hi_prio_oe(hi_oe),
    .bus_request_grant_lo_prio_in(lo_pin), .bus_request_grant_lo_prio_out(lo_out),
    .bus_request_grant_lo_prio_oe(lo_oe), .bus_hold_off_n_out(hold_out), .bus_hold_off_n_oe(hold_oe),
    .queue_status_hi(qs_hi), .queue_status_lo(qs_lo), .bus_released(released));
  brl_far_master brl_far_master_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req_hi),
    .pin_level(hi_pin), .hold_off_level(hold_lvl), .pull(hi_pull), .owns());
  brl_far_master brl_far_master_lo_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req_lo),
    .pin_level(lo_pin), .hold_off_level(hold_lvl), .pull(lo_pull), .owns());

  // Free-running 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Two bus cycles (or idle) with a request at clock k; grant seen at clock exp_g
  task automatic scen(input bit ch, input bit idle, input int k, input bit od, input bit ak,
      input int lk, input int dn, input int exp_g);
    int g;
    g = -1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      #1;
      if (g < 0 && (ch ? lo_oe : hi_oe) === 1'b1) begin
        g = i;
        `CHK("hold_oe_in_grant", 1'b0, hold_oe)
        `CHK("queue_in_grant", 2'h0, {qs_hi, qs_lo})
        `CHK("grant_pin", 1'b0, ch ? lo_pin : hi_pin)
        `CHK("released_in_grant", 1'b1, released)
      end
      if (g >= 0 && i == g + 1) `CHK("grant_width", 1'b0, ch ? lo_oe : hi_oe)
      if (lk >= 0 && i == lk + 2) `CHK("lock_low", 1'b0, hold_out)
      if (dn >= 0 && i == dn + 2) `CHK("lock_end", 1'b1, hold_out)
      if (ak && (i == 3 || i == 5)) `CHK("ack_low", !max_mode, hold_out)
      if (ak && i == 7) `CHK("ack_end", 1'b1, hold_out)
      bus_phase = (idle || i >= 8) ? 3'h0 : seq[i % 4];
      odd = od && i < 4;
      ack1 = ak && i < 4;
      ack2 = ak && i >= 4 && i < 8;
      lock = (i == lk);
      done = (i == dn);
      req_hi = (i == k) && !ch;
      req_lo = (i == k) && ch;
    end
    `CHK("grant_clock", exp_g, g)
    `CHK("bus_back", 1'b0, released)
    `CHK("hold_oe_back", 1'b1, hold_oe)
  endtask

  // Every queue code, flush winning over a same-cycle first byte
  task automatic qtest;
    logic [1:0] exp_c [4];
    exp_c = '{brl_pkg::BRL_QS_NONE, brl_pkg::BRL_QS_FIRST, brl_pkg::BRL_QS_FLUSH, brl_pkg::BRL_QS_NEXT};
    for (int j = 0; j < 4; j++) begin
      @(posedge clk_sys);
      #1;
      q_first = (j == 1 || j == 2);
      q_flush = (j == 2);
      q_next = (j == 3);
      @(posedge clk_sys);
      #1;
      {q_first, q_flush, q_next} = 3'h0;
      `CHK("queue_code", exp_c[j], {qs_hi, qs_lo})
    end
    // The code stands one cycle only, then falls back to no operation
    @(posedge clk_sys);
    #1;
    `CHK("queue_idle", brl_pkg::BRL_QS_NONE, {qs_hi, qs_lo})
  endtask

  // Both pins request on an idle bus: high priority first, low one after the exchange and idle clock
  task automatic tie;
    int gh;
    int gl;
    gh = -1;
    gl = -1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      #1;
      if (gh < 0 && hi_oe === 1'b1) gh = i;
      if (gl < 0 && lo_oe === 1'b1) gl = i;
      req_hi = (i == 0);
      req_lo = (i == 0);
    end
    `CHK("tie_hi_grant", 2, gh)
    `CHK("tie_lo_grant", 9, gl)
    `CHK("tie_back", 1'b0, released)
  endtask

  // Main sequence
  initial begin
    {clk_sys, odd, ack1, ack2, lock, done, q_first, q_flush, q_next, req_hi, req_lo} = 11'h000;
    bus_phase = 3'h0;
    max_mode = 1'b1;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    `CHK("rst_hold_off", 2'h3, {hold_oe, hold_out})
    `CHK("rst_queue", 2'h0, {qs_hi, qs_lo})
    `CHK("rst_released", 1'b0, released)
    repeat (2) @(posedge clk_sys);
    scen(0, 1, 0, 0, 0, -1, -1, 2);
    scen(1, 1, 0, 0, 0, -1, -1, 2);
    scen(0, 0, 1, 0, 0, -1, -1, 4);
    scen(0, 0, 2, 0, 0, -1, -1, 8);
    scen(0, 0, 0, 1, 0, -1, -1, 8);
    scen(0, 0, 0, 0, 1, -1, -1, 8);
    scen(1, 0, 0, 0, 0, 0, 5, 8);
    // Minimum mode: acknowledge still defers release but raises no hold-off
    max_mode = 1'b0;
    scen(0, 0, 0, 0, 1, -1, -1, 8);
    max_mode = 1'b1;
    tie();
    qtest();
    // Reset again mid-run while a lock is held; hold-off must come back high
    lock = 1'b1;
    @(posedge clk_sys);
    #1;
    lock = 1'b0;
    sys_rst = 1'b1;
    @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    `CHK("rst2_hold_off", 2'h3, {hold_oe, hold_out})
    // Request at state four is served at the next cycle end, not at the idle after it
    scen(0, 0, 3, 0, 0, -1, -1, 8);
    end_of_test();
  end

  // Watchdog, well past the expected run of about 220 clocks
  initial begin
    #4000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
